// ==== hdl/rfi_cmd.sv ====
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rfi_cmd #(
  parameter logic [7:0] MFG_CODE   = 8'hA5, // arbitrary value
  parameter int         SEC_BLOCKS = rfi_pkg::SEC_BLOCKS
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [rfi_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rfi_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       rf_clk,
  input  wire rfi_pkg::rfi_link_t         rf_link,
  input  wire logic                       rf_field,
  input  wire logic                       tag_ready,
  input  wire logic [63:0]                tag_uid,
  input  wire logic [7:0]                 tag_dsfid,
  input  wire logic [7:0]                 tag_afi,
  output logic                            mem_req,
  output logic [15:0]                     mem_addr,
  input  wire logic                       mem_ack,
  input  wire logic [31:0]                mem_rdata,
  input  wire rfi_pkg::rfi_sec_t          mem_sec,
  output var rfi_pkg::rfi_tx_t            rf_tx,
  input  wire logic                       tx_ready,
  output logic                            rf_activity_pin_o,
  output logic                            rf_activity_pin_oe_n
);
  import rfi_pkg::*;

  localparam int SEC_SH = $clog2(SEC_BLOCKS);

  typedef enum logic [2:0] {S_IDLE, S_DEC, S_SLOT, S_FETCH, S_SEND} rfi_state_t;

  rfi_state_t state_q;
  rfi_link_t  lk1_q;
  rfi_link_t  lk2_q;
  rfi_tx_t    tx_q;
  logic [2:0]  ck_q;
  logic [1:0]  fld_q;
  logic        rise;
  logic        pwr_off;
  logic        req_end;
  logic        slot_mark;
  logic [7:0]  req_q [REQ_MAX];
  logic [4:0]  cnt_q;
  logic        in_frm_q;
  logic        ovf_q;
  logic        crc_q;
  logic        arm_q;
  logic        busy_q;
  logic        hold_q;
  logic        ctrl_q;
  logic [79:0] buf_q;
  logic [3:0]  left_q;
  logic        more_q;
  logic        opt_q;
  logic        first_q;
  logic [15:0] blk_q;
  logic [7:0]  rem_q;
  logic [3:0]  slot_q;
  logic [3:0]  tgt_q;
  logic        mreq_q;
  logic [15:0] maddr_q;
  logic        oe_n_q;
  logic        pin_q;
  logic        aw_w_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        ar_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // two-flop sync; link edges from synced clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ck_q  <= '0;
      lk1_q <= '0;
      lk2_q <= '0;
      fld_q <= '0;
    end else begin
      ck_q  <= {ck_q[1:0], rf_clk};
      lk1_q <= rf_link;
      lk2_q <= lk1_q;
      fld_q <= {fld_q[0], rf_field};
    end
  end

  assign rise      = ck_q[1] & ~ck_q[2];
  assign pwr_off   = ~fld_q[1];
  assign req_end   = rise & lk2_q.eof & in_frm_q & ~pwr_off;
  assign slot_mark = rise & lk2_q.eof & ~in_frm_q & ~pwr_off;

  // request capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q    <= '0;
      in_frm_q <= 1'b0;
      ovf_q    <= 1'b0;
      crc_q    <= 1'b0;
    end else if (pwr_off) begin
      in_frm_q <= 1'b0;
    end else if (rise) begin
      if (lk2_q.sof) begin
        in_frm_q <= 1'b1;
        cnt_q    <= '0;
        ovf_q    <= 1'b0;
      end else if (in_frm_q & lk2_q.valid) begin
        if (cnt_q == 5'(REQ_MAX)) begin
          ovf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end else if (lk2_q.eof) begin
        in_frm_q <= 1'b0;
        crc_q    <= lk2_q.crc_ok;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rise & in_frm_q & lk2_q.valid & ~cnt_q[4]) begin
      req_q[cnt_q[3:0]] <= lk2_q.data;
    end
  end

  // request decode
  logic [7:0]  fl;
  logic [7:0]  cmd;
  logic [4:0]  n;
  logic [3:0]  p;
  logic [3:0]  q;
  logic [7:0]  ml;
  logic [63:0] mask;
  logic [63:0] mmask;
  logic [15:0] blk;
  logic [15:0] blk_end;
  logic [3:0]  slot;
  logic        base_ok;
  logic        uid_ok;
  logic        afi_ok;
  logic        arm_ok;
  logic        inv_ok;
  logic        rd_ok;

  always_comb begin
    fl      = req_q[IDX_FLAGS];
    cmd     = req_q[IDX_CMD];
    n       = cnt_q - CRC_BYTES;
    base_ok = crc_q & ~ovf_q & (cnt_q >= CRC_BYTES)
              & (req_q[IDX_MFG] == MFG_CODE);
    p       = fl[FL_ADR] ? 4'(IDX_PAR + UID_BYTES) : 4'(IDX_PAR);
    uid_ok  = 1'b1;
    for (int i = 0; i < UID_BYTES; i++) begin
      if (req_q[IDX_PAR + i] != tag_uid[8*i +: 8]) begin
        uid_ok = 1'b0;
      end
    end
    blk     = {req_q[p + 4'h1], req_q[p]};
    blk_end = blk + 16'(req_q[p + 4'h2]);
    q       = fl[FL_AFI] ? 4'(IDX_PAR + 1) : 4'(IDX_PAR);
    ml      = req_q[q];
    for (int i = 0; i < UID_BYTES; i++) begin
      mask[8*i +: 8] = req_q[4'(q + 1 + i)];
    end
    mmask   = (ml >= 8'(MASK_MAX)) ? '1 : ((64'h1 << ml) - 64'h1);
    slot    = 4'(tag_uid >> ml);
    afi_ok  = ~fl[FL_AFI] | (req_q[IDX_PAR] == '0) | (req_q[IDX_PAR] == tag_afi);
    // arms: non-addressed, ready
    arm_ok  = base_ok & tag_ready & (n == 5'(IDX_PAR))
              & ~fl[FL_SEL] & ~fl[FL_ADR] & ~fl[FL_INV];
    inv_ok  = base_ok & arm_q & fl[FL_INV] & (ml <= 8'(MASK_MAX)) & afi_ok
              & (((tag_uid ^ mask) & mmask) == '0)
              & (n == 5'(q) + 5'h01 + 5'((ml + 8'h07) >> 3));
    rd_ok   = base_ok & ~fl[FL_INV] & (n == 5'(p) + 5'(RD_PAR_LEN))
              & (~fl[FL_ADR] | uid_ok);
  end

  // reply selection
  logic        ld;
  logic        ld_err;
  logic [7:0]  ec;
  logic [79:0] ld_buf;
  logic [3:0]  ld_len;
  logic        ld_more;
  logic        ld_fast;
  logic        go_slot;
  logic        go_rd;
  logic [7:0]  ss;

  always_comb begin
    ld      = 1'b0;
    ld_err  = 1'b0;
    ec      = ERR_OPT;
    ld_buf  = {tag_uid, tag_dsfid, RSP_OK};
    ld_len  = LEN_UID;
    ld_more = 1'b0;
    ld_fast = 1'b0;
    go_slot = 1'b0;
    go_rd   = 1'b0;
    ss      = {3'b000, mem_sec.pwd, mem_sec.rw, mem_sec.locked};
    unique case (state_q)
      S_DEC: begin
        case (cmd)
          CMD_QARM, CMD_NARM: begin
            if (arm_ok) begin
              ld_fast = (cmd == CMD_QARM);
              ld_err  = (cmd == CMD_QARM) & fl[FL_SUB];
              ld      = ~ld_err;
            end
          end
          CMD_AINV: begin
            if (inv_ok) begin
              ld      = fl[FL_SLOT1] | (slot == '0);
              go_slot = ~ld;
            end
          end
          CMD_FRMB: begin
            if (rd_ok) begin
              ld_fast = 1'b1;
              if (fl[FL_SUB] | ~fl[FL_PEXT]) begin
                ld_err = 1'b1;
              end else if ((blk > BLK_LAST) | (blk_end > BLK_LAST)
                           | (blk[15:SEC_SH] != blk_end[15:SEC_SH])) begin
                ld_err = 1'b1;
                ec     = ERR_ADDR;
              end else begin
                go_rd = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      S_SLOT: begin
        ld = slot_mark & (slot_q + 4'h1 == tgt_q);
      end
      S_FETCH: begin
        if (mem_ack) begin
          ld_fast = 1'b1;
          if (first_q & mem_sec.rprot) begin
            ld_err = 1'b1;
            ec     = ERR_RPROT;
          end else begin
            ld      = 1'b1;
            ld_buf  = opt_q ? 80'({mem_rdata, ss}) : 80'(mem_rdata);
            ld_len  = LEN_WORD + 4'(opt_q);
            ld_more = (rem_q != '0);
            if (first_q) begin
              ld_buf = {ld_buf[71:0], RSP_OK};
              ld_len = ld_len + 4'h1;
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (ld_err) begin
      ld     = 1'b1;
      ld_buf = 80'({ec, RSP_ERR});
      ld_len = LEN_ERR;
    end
  end

  logic hs;
  logic done;
  assign hs   = (state_q == S_SEND) & tx_q.valid & tx_ready;
  assign done = ((state_q == S_DEC) & ~ld & ~go_slot & ~go_rd)
                | (hs & (left_q == 4'h1) & ~more_q);

  // sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= S_IDLE;
      tx_q    <= '0;
      buf_q   <= '0;
      left_q  <= '0;
      more_q  <= 1'b0;
      opt_q   <= 1'b0;
      first_q <= 1'b0;
      blk_q   <= '0;
      rem_q   <= '0;
      slot_q  <= '0;
      tgt_q   <= '0;
      mreq_q  <= 1'b0;
      maddr_q <= '0;
    end else if (pwr_off) begin
      state_q    <= S_IDLE;
      tx_q.valid <= 1'b0;
      mreq_q     <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (req_end) begin
            state_q <= S_DEC;
          end
        end
        S_DEC: begin
          if (go_slot) begin
            slot_q  <= '0;
            tgt_q   <= slot;
            state_q <= S_SLOT;
          end else if (go_rd) begin
            blk_q   <= blk;
            rem_q   <= req_q[p + 4'h2];
            opt_q   <= fl[FL_OPT];
            first_q <= 1'b1;
            mreq_q  <= 1'b1;
            maddr_q <= blk;
            state_q <= S_FETCH;
          end else begin
            state_q <= S_IDLE;
          end
        end
        S_SLOT: begin
          if (req_end) begin
            state_q <= S_DEC;
          end else if (slot_mark) begin
            slot_q <= slot_q + 4'h1;
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            mreq_q <= 1'b0;
          end
        end
        S_SEND: begin
          if (hs) begin
            if (left_q != 4'h1) begin
              buf_q     <= buf_q >> 8;
              tx_q.data <= buf_q[15:8];
              tx_q.last <= (left_q == 4'h2) & ~more_q;
              left_q    <= left_q - 4'h1;
            end else begin
              tx_q.valid <= 1'b0;
              if (more_q) begin
                rem_q   <= rem_q - 8'h01;
                blk_q   <= blk_q + 16'h0001;
                first_q <= 1'b0;
                mreq_q  <= 1'b1;
                maddr_q <= blk_q + 16'h0001;
                state_q <= S_FETCH;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
        end
      endcase
      if (ld) begin
        state_q <= S_SEND;
        buf_q   <= ld_buf;
        left_q  <= ld_len;
        more_q  <= ld_more;
        tx_q    <= '{valid: 1'b1, last: 1'b0, fast: ld_fast, data: ld_buf[7:0]};
      end
    end
  end

  // arming latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_q <= 1'b0;
    end else if (pwr_off) begin
      arm_q <= 1'b0;
    end else if ((state_q == S_DEC) & ld & ~ld_err
                 & ((cmd == CMD_QARM) | (cmd == CMD_NARM))) begin
      arm_q <= 1'b1;
    end
  end

  // activity pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      oe_n_q <= 1'b1;
      pin_q  <= 1'b0;
    end else begin
      if (pwr_off) begin
        busy_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        if (done) begin
          busy_q <= 1'b0;
        end
        if (rise & lk2_q.sof) begin
          busy_q <= 1'b1;
        end
        if ((state_q == S_SLOT) & req_end) begin
          hold_q <= 1'b1;
        end
      end
      // wip mode never drives
      oe_n_q <= ~(ctrl_q & (busy_q | hold_q));
      pin_q  <= 1'b0;
    end
  end

  // register bus slave
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_w_q   <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      ctrl_q   <= 1'b0;
    end else begin
      aw_w_q <= 1'b0;
      if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (~aw_w_q & ~bvalid_q & s_axi_awvalid & s_axi_wvalid) begin
        aw_w_q   <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q  <= RESP_OKAY;
        if (s_axi_awaddr == OFS_CTRL) begin
          if (s_axi_wstrb[0]) begin
            ctrl_q <= s_axi_wdata[CTRL_BUSY_MODE];
          end
        end else if (s_axi_awaddr != OFS_STAT) begin
          bresp_q <= RESP_SLVERR;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ar_q     <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else begin
      ar_q <= 1'b0;
      if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      if (~ar_q & ~rvalid_q & s_axi_arvalid) begin
        ar_q     <= 1'b1;
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        rdata_q  <= '0;
        if (s_axi_araddr == OFS_CTRL) begin
          rdata_q <= 32'(ctrl_q);
        end else if (s_axi_araddr == OFS_STAT) begin
          rdata_q <= 32'({hold_q, busy_q, arm_q});
        end else begin
          rresp_q <= RESP_SLVERR;
        end
      end
    end
  end

  assign s_axi_awready        = aw_w_q;
  assign s_axi_wready         = aw_w_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = ar_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rresp          = rresp_q;
  assign s_axi_rdata          = rdata_q;
  assign mem_req              = mreq_q;
  assign mem_addr             = maddr_q;
  assign rf_tx                = tx_q;
  assign rf_activity_pin_o    = pin_q;
  assign rf_activity_pin_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ==== shared/rfi_pkg.sv ====
`default_nettype none
package rfi_pkg;
  localparam logic [7:0] CMD_QARM  = 8'hC2;
  localparam logic [7:0] CMD_NARM  = 8'hD2;
  localparam logic [7:0] CMD_AINV  = 8'hD1;
  localparam logic [7:0] CMD_FRMB  = 8'hC3;
  // request flag bit positions
  localparam int FL_SUB   = 0;
  localparam int FL_INV   = 2;
  localparam int FL_PEXT  = 3;
  localparam int FL_SEL   = 4;
  localparam int FL_AFI   = 4;
  localparam int FL_ADR   = 5;
  localparam int FL_SLOT1 = 5;
  localparam int FL_OPT   = 6;
  localparam logic [7:0] RSP_OK    = 8'h00;
  localparam logic [7:0] RSP_ERR   = 8'h01;
  localparam logic [7:0] ERR_OPT   = 8'h03;
  localparam logic [7:0] ERR_ADDR  = 8'h10;
  localparam logic [7:0] ERR_RPROT = 8'h15;
  localparam logic [15:0] BLK_LAST = 16'h01FF;
  localparam int SEC_BLOCKS = 32;
  localparam int UID_BYTES  = 8;
  localparam int REQ_MAX    = 16;
  localparam int MASK_MAX   = 64;
  // byte positions and lengths inside a request
  localparam int IDX_FLAGS  = 0;
  localparam int IDX_CMD    = 1;
  localparam int IDX_MFG    = 2;
  localparam int IDX_PAR    = 3;
  localparam int RD_PAR_LEN = 3;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  // reply chunk lengths in bytes
  localparam logic [3:0] LEN_UID  = 4'hA;
  localparam logic [3:0] LEN_ERR  = 4'h2;
  localparam logic [3:0] LEN_WORD = 4'h4;
  // register bus
  localparam int AXI_AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CTRL_BUSY_MODE = 0;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       valid;
    logic       crc_ok;
    logic [7:0] data;
  } rfi_link_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       fast;
    logic [7:0] data;
  } rfi_tx_t;

  typedef struct packed {
    logic       rprot;
    logic [1:0] pwd;
    logic [1:0] rw;
    logic       locked;
  } rfi_sec_t;
endpackage
`default_nettype wire

// ==== test/rfi_cmd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfi_cmd_assertions
  import rfi_pkg::*;
#(
  parameter int SEC_BLOCKS = 32
) (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic [rfi_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awready,
  input wire logic [3:0]                 s_axi_wstrb,
  input wire logic [31:0]                s_axi_wdata,
  input wire logic [rfi_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       rf_field,
  input wire logic                       mem_req,
  input wire logic [15:0]                mem_addr,
  input wire logic                       mem_ack,
  input wire rfi_pkg::rfi_tx_t           rf_tx,
  input wire logic                       tx_ready,
  input wire logic                       rf_activity_pin_o,
  input wire logic                       rf_activity_pin_oe_n
);
  logic                mode_q;
  logic                arm_q;
  logic                in_rd_q;
  logic [AXI_AW-1:0]   rd_a_q;
  logic [15:0]         sec_q;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // activity mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) mode_q <= 1'b0;
    else if (s_axi_awready && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0])
      mode_q <= s_axi_wdata[CTRL_BUSY_MODE];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rd_a_q <= '0;
    else if (s_axi_arvalid) rd_a_q <= s_axi_araddr;
  end

  // latch once read set; held until field loss
  always_ff @(posedge clk or posedge reset) begin
    if (reset) arm_q <= 1'b0;
    else if (!rf_field) arm_q <= 1'b0;
    else if (s_axi_rvalid && s_axi_rready && rd_a_q == OFS_STAT && s_axi_rdata[0]) arm_q <= 1'b1;
  end

  // sector of first fetched block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_rd_q <= 1'b0;
      sec_q   <= '0;
    end else if (!rf_field || (rf_tx.valid && tx_ready && rf_tx.last)) begin
      in_rd_q <= 1'b0;
    end else if (mem_req && !in_rd_q) begin
      in_rd_q <= 1'b1;
      sec_q   <= mem_addr / 16'(SEC_BLOCKS);
    end
  end

  a_wip_released: assert property (!mode_q |-> rf_activity_pin_oe_n)
    else $error("activity pin driven in write-progress mode");
  a_busy_reply: assert property (mode_q && rf_tx.valid |-> !rf_activity_pin_oe_n)
    else $error("activity pin released during reply");
  a_pin_zero: assert property (!rf_activity_pin_oe_n |-> !rf_activity_pin_o)
    else $error("activity pin driven high");
  a_latch_sticky: assert property (arm_q && s_axi_rvalid && rd_a_q == OFS_STAT |-> s_axi_rdata[0])
    else $error("arming latch cleared without power loss");
  a_quiet_unpowered: assert property (!rf_field [*6] |-> !rf_tx.valid)
    else $error("reply byte while unpowered");
  a_blk_range: assert property (mem_req |-> mem_addr <= BLK_LAST)
    else $error("block fetch beyond last block");
  a_req_hold: assert property (mem_req && !mem_ack && rf_field |=> mem_req && $stable(mem_addr))
    else $error("block fetch dropped before acknowledge");
  a_one_sector: assert property (mem_req && in_rd_q |-> mem_addr / 16'(SEC_BLOCKS) == sec_q)
    else $error("multi-block read crossed a sector");

  c_fast_last: cover property (rf_tx.valid && tx_ready && rf_tx.last && rf_tx.fast);
  c_mem_ack: cover property (mem_ack);
  c_pin_low: cover property (!rf_activity_pin_oe_n);
endmodule

bind rfi_cmd rfi_cmd_assertions #(.SEC_BLOCKS(SEC_BLOCKS)) chk_u (.*);
`default_nettype wire

// ==== test/rfi_reader_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfi_reader_model
  import rfi_pkg::*;
(
  input  wire logic              clk,
  output logic                   rf_clk,
  output var rfi_pkg::rfi_link_t rf_link,
  input  wire rfi_pkg::rfi_tx_t  rf_tx,
  output logic                   tx_ready
);
  logic [7:0] req_q[$];
  logic [8:0] rx_q[$];
  logic       rx_done;
  integer     sd = 61;

  initial begin
    rf_clk   = 1'b0;
    rf_link  = '0;
    tx_ready = 1'b0;
    rx_done  = 1'b0;
  end

  // one link cycle; pins then show inverted data
  task automatic item(input logic [3:0] f, input logic [7:0] d);
    rf_link = {f, d};
    #16 rf_clk = 1'b1;
    #16 rf_clk = 1'b0;
    rf_link = {4'h0, ~d};
  endtask

  task automatic send(input logic ok);
    #1;
    item(4'h8, 8'h00);
    foreach (req_q[i]) item(4'h2, req_q[i]);
    item({3'b010, ok}, 8'h00);
    req_q.delete();
  endtask

  // reply sink with random stalls
  always @(posedge clk) begin
    tx_ready <= ($random(sd) & 3) != 0;
    if (rf_tx.valid && tx_ready) begin
      rx_q.push_back({rf_tx.fast, rf_tx.data});
      if (rf_tx.last) rx_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== test/rfi_cmd_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfi_cmd_tb;
  import rfi_pkg::*;
  localparam logic [7:0] MFG = 8'h3C; // arbitrary maker value
  logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rf_clk, rf_field, tag_ready, mem_req, mem_ack, tx_ready;
  logic        rf_activity_pin_o, rf_activity_pin_oe_n, op;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_rdata, rd_v, w;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr_v;
  logic [63:0] tag_uid;
  logic [7:0]  tag_dsfid, tag_afi, cn;
  logic [15:0] mem_addr, st;
  logic [7:0]  exp_q[$];
  rfi_link_t   rf_link;
  rfi_sec_t    mem_sec, sec_v;
  rfi_tx_t     rf_tx;
  integer      seed = 61, failures = 0, cmp_count = 0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  rfi_cmd #(.MFG_CODE(MFG), .SEC_BLOCKS(32)) dut_u (.*);
  rfi_reader_model rdr_u (.clk, .rf_clk, .rf_link, .rf_tx, .tx_ready);

  function automatic logic [31:0] blk(input logic [15:0] a);
    return {a, ~a};
  endfunction
  function automatic logic [7:0] sbyte(input rfi_sec_t s);
    return {3'b000, s.pwd, s.rw, s.locked};
  endfunction

  // block store, random latency
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack && ($random(seed) & 1)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= blk(mem_addr);
      mem_sec   <= sec_v;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    end while (s_axi_bvalid !== 1'b1);
    rr_v = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    rr_v = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic frm(input logic [7:0] fl, input logic [7:0] cmd, input logic [7:0] mfg);
    rdr_u.req_q = '{fl, cmd, mfg};
  endtask
  task automatic go(input logic ok);
    rdr_u.req_q.push_back(8'h5A);
    rdr_u.req_q.push_back(8'hC3);
    rdr_u.send(ok);
  endtask

  // empty exp_q: expect silence
  task automatic rsp(input logic f);
    if (exp_q.size() == 0) repeat (300) @(posedge clk);
    else while (rdr_u.rx_done !== 1'b1) @(posedge clk);
    chk("reply length", exp_q.size(), rdr_u.rx_q.size());
    foreach (exp_q[i]) if (i < rdr_u.rx_q.size()) chk("reply byte", {f, exp_q[i]}, rdr_u.rx_q[i]);
    exp_q.delete();
    rdr_u.rx_q.delete();
    rdr_u.rx_done = 1'b0;
  endtask

  task automatic silent(input logic [7:0] fl, input logic [7:0] cmd, input logic [7:0] m, input logic ok);
    frm(fl, cmd, m);
    if (cmd == CMD_AINV) rdr_u.req_q.push_back(8'h00);
    go(ok);
    rsp(1'b0);
  endtask

  task automatic exp_uid();
    exp_q = '{8'h00, tag_dsfid};
    for (int i = 0; i < 8; i++) exp_q.push_back(tag_uid[8*i +: 8]);
  endtask

  task automatic mrd(input logic [7:0] fl, input logic [15:0] s, input logic [7:0] c);
    frm(fl, CMD_FRMB, MFG);
    rdr_u.req_q.push_back(s[7:0]);
    rdr_u.req_q.push_back(s[15:8]);
    rdr_u.req_q.push_back(c);
    go(1'b1);
  endtask

  task automatic rerr(input logic [7:0] fl, input logic [15:0] s, input logic [7:0] c, input logic [7:0] code);
    mrd(fl, s, c);
    exp_q = '{RSP_ERR, code};
    rsp(1'b1);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_rdata, mem_ack, mem_sec, sec_v} = '0;
    s_axi_wstrb = 4'hF;
    {rf_field, tag_ready} = 2'b01;
    tag_uid = {$random(seed), $random(seed)};
    tag_uid[3:0] = 4'h3;
    {tag_dsfid, tag_afi} = 16'($random(seed));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rf_field <= 1'b1;
    axi_rd(OFS_CTRL);
    chk("ctrl reset", 32'h0, rd_v);
    axi_wr(OFS_CTRL, 32'h1);
    chk("write resp", RESP_OKAY, rr_v);
    s_axi_wstrb <= 4'h0;
    axi_wr(OFS_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    axi_rd(OFS_CTRL);
    chk("ctrl", 32'h1, rd_v);
    axi_rd(4'hC);
    chk("unmapped resp", RESP_SLVERR, rr_v);
    chk("unmapped data", 32'h0, rd_v);
    $display("test registers done");
    silent(8'h24, CMD_AINV, MFG, 1'b1);
    tag_ready <= 1'b0;
    silent(8'h00, CMD_NARM, MFG, 1'b1);
    tag_ready <= 1'b1;
    silent(8'h10, CMD_QARM, MFG, 1'b1);
    silent(8'h20, CMD_NARM, MFG, 1'b1);
    silent(8'h00, CMD_QARM, MFG, 1'b0);
    silent(8'h00, CMD_QARM, MFG ^ 8'h01, 1'b1);
    frm(8'h01, CMD_QARM, MFG);
    go(1'b1);
    exp_q = '{RSP_ERR, ERR_OPT};
    rsp(1'b1);
    axi_rd(OFS_STAT);
    chk("latch clear", 0, rd_v[0]);
    $display("test silent cases done");
    frm(8'h00, CMD_QARM, MFG);
    go(1'b1);
    exp_uid();
    rsp(1'b1);
    axi_rd(OFS_STAT);
    chk("latch set", 1, rd_v[0]);
    frm(8'h00, CMD_NARM, MFG);
    go(1'b1);
    exp_uid();
    rsp(1'b0);
    silent(8'h20, CMD_AINV, MFG, 1'b1);
    frm(8'h24, CMD_AINV, MFG);
    rdr_u.req_q.push_back(8'h00);
    go(1'b1);
    exp_uid();
    rsp(1'b0);
    $display("test arming done");
    for (int k = 0; k < 8; k++) begin
      st = (k == 0) ? 16'h01E0 : 16'($random(seed)) & BLK_LAST;
      cn = (k == 0) ? 8'd31 : 8'($unsigned($random(seed)) % (32 - st[4:0]));
      op = $random(seed);
      sec_v = 6'($random(seed));
      sec_v.rprot = 1'b0;
      mrd({1'b0, op, 6'h08}, st, cn);
      exp_q = '{RSP_OK};
      for (int b = 0; b <= cn; b++) begin
        w = blk(st + 16'(b));
        if (op) exp_q.push_back(sbyte(sec_v));
        for (int j = 0; j < 4; j++) exp_q.push_back(w[8*j +: 8]);
      end
      rsp(1'b1);
    end
    rerr(8'h00, 16'h0005, 8'h00, ERR_OPT);
    rerr(8'h09, 16'h0005, 8'h00, ERR_OPT);
    rerr(8'h08, 16'h001F, 8'h01, ERR_ADDR);
    rerr(8'h08, 16'h0200, 8'h00, ERR_ADDR);
    sec_v.rprot = 1'b1;
    rerr(8'h08, 16'h0040, 8'h03, ERR_RPROT);
    $display("test block reads done");
    frm(8'h04, CMD_AINV, MFG);
    rdr_u.req_q.push_back(8'h00);
    go(1'b1);
    silent(8'h00, CMD_QARM, MFG, 1'b0);
    chk("pin held", 0, rf_activity_pin_oe_n);
    rf_field <= 1'b0;
    repeat (12) @(posedge clk);
    chk("pin freed", 1, rf_activity_pin_oe_n);
    rf_field <= 1'b1;
    axi_rd(OFS_STAT);
    chk("latch after power loss", 0, rd_v[0]);
    axi_wr(OFS_CTRL, 32'h0);
    frm(8'h00, CMD_NARM, MFG);
    go(1'b1);
    exp_uid();
    rsp(1'b0);
    chk("pin released", 1, rf_activity_pin_oe_n);
    $display("test power and pin modes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
